// ---- design/tcc_pkg.sv ----
// tcc_pkg: register map, field positions and encodings of the timer block
package tcc_pkg;
    // register offsets, 16-bit address space
    localparam logic [15:0] TCC_ADR_COUNT = 16'hff10;
    localparam logic [15:0] TCC_ADR_CC0 = 16'hff12;
    localparam logic [15:0] TCC_ADR_MODE = 16'hffba;
    localparam logic [15:0] TCC_ADR_CCCTL = 16'hff20;
    localparam logic [15:0] TCC_ADR_EDGE = 16'hff22;
    localparam logic [15:0] TCC_ADR_OSHOT = 16'hff24;
    localparam logic [15:0] TCC_ADR_IRQ_ST = 16'hff28;
    localparam logic [15:0] TCC_ADR_IRQ_CLR = 16'hff2a;
    localparam logic [15:0] TCC_ADR_IRQ_EN = 16'hff2c;
    // reset values and the counter top value
    localparam logic [15:0] TCC_RST_COUNT = 16'h0000;
    localparam logic [15:0] TCC_RST_CC0 = 16'h0000;
    localparam logic [2:0] TCC_RST_MODE = 3'h0;
    localparam logic [1:0] TCC_RST_IRQ = 2'h0;
    localparam logic [15:0] TCC_CNT_MAX = 16'hffff;
    // timer_mode_control fields
    localparam int TCC_MODE_LO = 1;
    localparam int TCC_MODE_HI = 3;
    localparam int TCC_OVF_BIT = 0;
    // capture_compare_control fields
    localparam int TCC_CAP_SEL_BIT = 0;
    localparam int TCC_TRG_SRC_BIT = 1;
    // prescaler_edge_config fields
    localparam int TCC_EDGE_A_LO = 4;
    localparam int TCC_EDGE_B_LO = 6;
    // one-shot register fields
    localparam int TCC_OS_TRIG_BIT = 0;
    localparam int TCC_OS_MODE_BIT = 1;
    // interrupt status bits
    localparam int TCC_IRQ_CC0 = 0;
    localparam int TCC_IRQ_OVF = 1;
    // edge codes, 2'b10 is prohibited
    localparam logic [1:0] TCC_ES_FALL = 2'h0;
    localparam logic [1:0] TCC_ES_RISE = 2'h1;
    localparam logic [1:0] TCC_ES_BOTH = 2'h3;
    // counter operating modes from the upper two mode bits
    typedef enum logic [1:0] {
        TCC_OP_STOP,
        TCC_OP_FREE,
        TCC_OP_EDGE_CLR,
        TCC_OP_MATCH_CLR
    } tcc_op_t;
endpackage

// ---- design/tcc_timer.sv ----
// tcc_timer: 16-bit timer counter with capture/compare register zero
// Function
// - 16-bit counter increments every count clock
// - counter readable, writes ignored
// - reset forces counter to zero
// - stop mode clears the counter
// - input a valid edge clears, restarts
// - match with register zero clears counter
// - one-shot trigger write clears counter
// - control bit 0 picks compare/capture
// - register zero written as one word
// - reset clears register zero
// - compare match raises register-zero interrupt
// - compare value held until rewritten
// - trigger source bit picks input a/b
// - input a capture uses opposite edge; code 11 never captures
// - input b capture uses selected edge
// - nonzero upper mode bits start counting
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module tcc_timer (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // register port
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    output logic [15:0] rd_data_o,
    // timer input pins, asynchronous
    input wire logic timer_input_a_i,
    input wire logic timer_input_b_i,
    // interrupts
    output logic cc_zero_match_irq_o,
    output logic irq_o
);
    import tcc_pkg::*;

    // software state
    // all control state resets to zero, which is the stop mode
    logic [15:0] count_q; // timer_count_value
    logic [15:0] count_d;
    logic [15:0] cc0_q; // capture_compare_zero
    logic [2:0] mode_q; // timer_mode_control bits 3:1
    logic ovf_q; // overflow flag
    logic cap_sel_q; // cc_zero_capture_select
    logic trg_src_q; // cc_zero_trigger_source
    logic [1:0] edge_a_q; // input_a edge select
    logic [1:0] edge_b_q; // input_b edge select
    logic os_mode_q; // one-shot pulse mode enable
    logic [1:0] irq_st_q; // sticky status
    logic [1:0] irq_en_q; // interrupt enables
    logic [15:0] rd_data_q;
    logic irq_q;
    logic match_irq_q;

    // decoded strobes
    // exact 16-bit decode; the status address has no write strobe at all
    logic wr_count, wr_cc0, wr_mode, wr_ccctl, wr_edge;
    logic wr_oshot, wr_irq_clr, wr_irq_en;
    assign wr_count = wr_en_i && (addr_i == TCC_ADR_COUNT);
    assign wr_cc0 = wr_en_i && (addr_i == TCC_ADR_CC0);
    assign wr_mode = wr_en_i && (addr_i == TCC_ADR_MODE);
    assign wr_ccctl = wr_en_i && (addr_i == TCC_ADR_CCCTL);
    assign wr_edge = wr_en_i && (addr_i == TCC_ADR_EDGE);
    assign wr_oshot = wr_en_i && (addr_i == TCC_ADR_OSHOT);
    assign wr_irq_clr = wr_en_i && (addr_i == TCC_ADR_IRQ_CLR);
    assign wr_irq_en = wr_en_i && (addr_i == TCC_ADR_IRQ_EN);

    // operating mode from the upper two mode bits
    tcc_op_t op;
    logic run;
    assign op = tcc_op_t'(mode_q[2:1]);
    assign run = (op != TCC_OP_STOP);

    // pin synchronisers and edge detectors, one per input
    logic [1:0] pin_raw;
    logic [1:0] rise, fall;
    assign pin_raw = {timer_input_b_i, timer_input_a_i};
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pin
            logic s1_q, s2_q, prev_q;
            // two flops before any logic looks at the pin
            // the edge flop adds one cycle, so a pin change is seen three edges on
            always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    prev_q <= 1'b0;
                end else begin
                    s1_q <= pin_raw[gi];
                    s2_q <= s1_q;
                    prev_q <= s2_q;
                end
            end
            assign rise[gi] = s2_q && !prev_q;
            assign fall[gi] = !s2_q && prev_q;
        end
    endgenerate

    // valid edge of input a, as used for clearing
    // only the clear-on-edge mode looks at this; code 10 never qualifies
    logic a_valid;
    always_comb begin
        unique case (edge_a_q)
            TCC_ES_FALL: a_valid = fall[0];
            TCC_ES_RISE: a_valid = rise[0];
            TCC_ES_BOTH: a_valid = rise[0] | fall[0];
            default: a_valid = 1'b0; // prohibited code
        endcase
    end

    // capture edge from input a runs opposite to its valid edge
    // limitation: code 11 on input a never captures, whatever the pin does
    logic a_cap;
    always_comb begin
        unique case (edge_a_q)
            TCC_ES_RISE: a_cap = fall[0];
            TCC_ES_FALL: a_cap = rise[0];
            default: a_cap = 1'b0; // both edges: no capture
        endcase
    end

    // capture edge from input b follows its code
    logic b_cap;
    always_comb begin
        unique case (edge_b_q)
            TCC_ES_FALL: b_cap = fall[1];
            TCC_ES_RISE: b_cap = rise[1];
            TCC_ES_BOTH: b_cap = rise[1] | fall[1];
            default: b_cap = 1'b0; // code 10 must not be used
        endcase
    end

    // capture, match and clear conditions
    logic cap_evt, hit, match_evt;
    logic clr_edge, clr_match, clr_os, clr_any, ovf_evt;
    // no capture while stopped: the count would be meaningless
    assign cap_evt = run && cap_sel_q && (trg_src_q ? a_cap : b_cap);
    assign hit = (count_q == cc0_q);
    assign match_evt = run && !cap_sel_q && hit;
    assign clr_edge = (op == TCC_OP_EDGE_CLR) && a_valid;
    assign clr_match = (op == TCC_OP_MATCH_CLR) && hit;
    assign clr_os = run && os_mode_q && wr_oshot && wr_data_i[TCC_OS_TRIG_BIT];
    assign clr_any = clr_edge || clr_match || clr_os;
    // overflow only on a true wrap, not when a clear lands on the top value
    assign ovf_evt = run && !clr_any && (count_q == TCC_CNT_MAX);

    // next count; the bus write to the count address plays no part
    // stop mode holds the count at zero rather than freezing it
    always_comb begin
        if (!run) begin
            count_d = TCC_RST_COUNT;
        end else if (clr_any) begin
            count_d = TCC_RST_COUNT;
        end else begin
            count_d = count_q + 16'h0001; // wraps at the top
        end
    end

    // counter register
    // no write path exists; software disturbs a running count only by a one-shot trigger or a stop
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_q <= TCC_RST_COUNT;
        end else begin
            count_q <= count_d;
        end
    end

    // capture/compare register zero
    // capture outranks a colliding write: the captured count is the live data
    // a write while running is accepted, but software is expected to avoid it
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cc0_q <= TCC_RST_CC0;
        end else if (cap_evt) begin
            cc0_q <= count_q;
        end else if (wr_cc0) begin
            cc0_q <= wr_data_i; // whole word at once
        end
    end

    // mode control and overflow flag; overflow set beats a clearing write
    // the lowest stored mode bit does not change the run or stop decode
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_q <= TCC_RST_MODE;
            ovf_q <= 1'b0;
        end else begin
            if (wr_mode) begin
                mode_q <= wr_data_i[TCC_MODE_HI:TCC_MODE_LO];
            end
            if (ovf_evt) begin
                ovf_q <= 1'b1;
            end else if (wr_mode) begin
                ovf_q <= wr_data_i[TCC_OVF_BIT];
            end
        end
    end

    // capture/compare control, edge selects, one-shot mode
    // changes take effect at the next edge; no shadow copy is kept
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cap_sel_q <= 1'b0;
            trg_src_q <= 1'b0;
            edge_a_q <= TCC_ES_FALL;
            edge_b_q <= TCC_ES_FALL;
            os_mode_q <= 1'b0;
        end else begin
            if (wr_ccctl) begin
                cap_sel_q <= wr_data_i[TCC_CAP_SEL_BIT];
                trg_src_q <= wr_data_i[TCC_TRG_SRC_BIT];
            end
            if (wr_edge) begin
                edge_a_q <= wr_data_i[TCC_EDGE_A_LO+1:TCC_EDGE_A_LO];
                edge_b_q <= wr_data_i[TCC_EDGE_B_LO+1:TCC_EDGE_B_LO];
            end
            if (wr_oshot) begin
                os_mode_q <= wr_data_i[TCC_OS_MODE_BIT];
            end
        end
    end

    // sticky status: hardware set wins over a same-cycle clear
    // so a clear written in the cycle of an event cannot lose that event
    logic [1:0] irq_evt;
    logic [1:0] irq_clr;
    assign irq_evt[TCC_IRQ_CC0] = match_evt || cap_evt;
    assign irq_evt[TCC_IRQ_OVF] = ovf_evt;
    assign irq_clr = wr_irq_clr ? wr_data_i[1:0] : 2'h0;
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_st_q <= TCC_RST_IRQ;
            irq_en_q <= TCC_RST_IRQ;
        end else begin
            irq_st_q <= (irq_st_q & ~irq_clr) | irq_evt;
            if (wr_irq_en) begin
                irq_en_q <= wr_data_i[1:0];
            end
        end
    end

    // interrupt outputs, registered; the request pulse lags its event by one
    // both outputs are flops so the pins never glitch on decode
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_q <= 1'b0;
            match_irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_st_q & irq_en_q);
            match_irq_q <= irq_evt[TCC_IRQ_CC0];
        end
    end

    // read mux; data valid only in the cycle after the strobe
    // a read that meets a capture returns the value held before it
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        unique case (addr_i)
            TCC_ADR_COUNT: rd_mux = count_q;
            TCC_ADR_CC0: rd_mux = cc0_q;
            TCC_ADR_MODE: rd_mux = {12'h000, mode_q, ovf_q};
            TCC_ADR_CCCTL: rd_mux = {14'h0000, trg_src_q, cap_sel_q};
            TCC_ADR_EDGE: rd_mux = {8'h00, edge_b_q, edge_a_q, 4'h0};
            TCC_ADR_OSHOT: rd_mux = {14'h0000, os_mode_q, 1'b0};
            TCC_ADR_IRQ_ST: rd_mux = {14'h0000, irq_st_q};
            TCC_ADR_IRQ_EN: rd_mux = {14'h0000, irq_en_q};
            default: rd_mux = 16'h0000; // unmapped and write-only read zero
        endcase
    end
    // zero outside the answer cycle keeps the idle bus quiet
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_q <= 16'h0000;
        end else begin
            rd_data_q <= rd_en_i ? rd_mux : 16'h0000;
        end
    end

    // outputs straight from their flops
    assign rd_data_o = rd_data_q;
    assign irq_o = irq_q;
    assign cc_zero_match_irq_o = match_irq_q;

    // checks on the counter
    chk_stop_clears: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        !run |=> (count_q == 16'h0000))
        else $error("counter not zero after stop");
    chk_count_step: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        run && !clr_any |=> count_q == 16'($past(count_q) + 16'h0001))
        else $error("counter did not advance by one");
    chk_write_ignored: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        wr_count && run && !clr_any |=> count_q == 16'($past(count_q) + 16'h0001))
        else $error("counter write had an effect");
    chk_edge_clear: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (op == TCC_OP_EDGE_CLR) && a_valid |=> count_q == 16'h0000)
        else $error("input edge did not clear counter");
    chk_match_clear: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (op == TCC_OP_MATCH_CLR) && hit |=> count_q == 16'h0000 ##1 count_q <= 16'h0001)
        else $error("match did not clear counter");
    chk_oneshot_clr: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        clr_os |=> count_q == 16'h0000)
        else $error("one-shot trigger did not clear counter");
    // checks on register zero and the interrupts
    chk_cmp_hold: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        !cap_sel_q && !wr_cc0 && !cap_evt |=> $stable(cc0_q))
        else $error("compare value changed without a write");
    chk_match_irq: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        run && !cap_sel_q && hit |=> cc_zero_match_irq_o && irq_st_q[TCC_IRQ_CC0])
        else $error("match did not raise interrupt");
    chk_capture_load: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        cap_evt |=> cc0_q == $past(count_q))
        else $error("capture did not load count");
    chk_a_no_cap: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        trg_src_q && edge_a_q == TCC_ES_BOTH |-> !cap_evt)
        else $error("input a both edges captured");
    chk_cc0_write: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        wr_cc0 && !cap_evt |=> cc0_q == $past(wr_data_i))
        else $error("register zero write lost");
    chk_irq_level: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        |(irq_st_q & irq_en_q) |=> irq_o) // interrupt follows status
        else $error("interrupt output not raised");
    chk_irq_low: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        !(|(irq_st_q & irq_en_q)) |=> !irq_o) // interrupt drops with status
        else $error("interrupt output not lowered");
    chk_status_sticky: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        irq_st_q[TCC_IRQ_CC0] && !(wr_irq_clr && wr_data_i[TCC_IRQ_CC0])
        |=> irq_st_q[TCC_IRQ_CC0]) // status holds until cleared
        else $error("status bit lost without a clear");
    chk_match_pulse: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        !irq_evt[TCC_IRQ_CC0] |=> !cc_zero_match_irq_o)
        else $error("request pulse without an event");
    chk_stop_quiet: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        !run |=> !cc_zero_match_irq_o)
        else $error("request pulse while stopped");

    // checks on reset and the read port
    chk_reset_values: assert property (@(posedge clk_sys_i)
        $rose(reset_n_i) |-> count_q == 16'h0000 && cc0_q == 16'h0000)
        else $error("count or register zero not cleared by reset");
    chk_rd_idle: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        !rd_en_i |=> rd_data_o == 16'h0000) // read data only after a strobe
        else $error("read data outside the answer cycle");

    // checks on capture edges
    chk_a_fall_cap: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        run && cap_sel_q && trg_src_q && edge_a_q == TCC_ES_RISE && fall[0]
        |=> cc0_q == $past(count_q))
        else $error("input a falling edge not captured");
    chk_b_both_cap: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        run && cap_sel_q && !trg_src_q && edge_b_q == TCC_ES_BOTH && (rise[1] || fall[1])
        |=> cc0_q == $past(count_q))
        else $error("input b edge not captured");
    chk_cap_stopped: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        !run && cap_sel_q |=> $stable(cc0_q) || $past(wr_cc0)) // no capture while stopped
        else $error("capture while stopped");

    // main scenarios
    cov_match_clear: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        clr_match);
    cov_capture_b: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        cap_evt && !trg_src_q);
    cov_capture_a: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        cap_evt && trg_src_q);
    cov_overflow: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        ovf_evt);
    cov_oneshot_clr: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        clr_os);
endmodule // tcc_timer
`default_nettype wire

// ---- verif/tcc_pin_model.sv ----
// tcc_pin_model: outside source driving the two timer input pins
`timescale 1ns/100ps
`default_nettype none
module tcc_pin_model (
    // clock
    input wire logic clk_sys_i,
    // pins toward the timer
    output logic timer_input_a_o,
    output logic timer_input_b_o
);
    // both pins rest low from time zero
    initial begin
        timer_input_a_o = 1'b0;
        timer_input_b_o = 1'b0;
    end

    // move one pin just after an edge, then hold it; four clocks
    // leaves margin over the two-flop synchroniser and edge flop
    task automatic drive_pin(input logic sel_b, input logic level);
        @(posedge clk_sys_i);
        if (sel_b) begin
            timer_input_b_o <= level;
        end else begin
            timer_input_a_o <= level;
        end
        repeat (4) @(posedge clk_sys_i);
    endtask
endmodule // tcc_pin_model
`default_nettype wire

// ---- verif/tcc_timer_test.sv ----
// tcc_timer_test: self-checking bench for the timer counter block
`timescale 1ns/100ps
`default_nettype none
module tcc_timer_test;
    import tcc_pkg::*;
    // design connections
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic [15:0] wr_data_i = 16'h0000;
    logic wr_en_i = 1'b0;
    logic rd_en_i = 1'b0;
    logic [15:0] rd_data_o;
    logic pin_a;
    logic pin_b;
    logic cc_zero_match_irq_o;
    logic irq_o;
    // bookkeeping
    int miscompares = 0;
    int cmp_count = 0;
    logic [15:0] rv;
    logic [15:0] rv2;

    // 100 ns system clock
    always #50 clk_sys_i = ~clk_sys_i;

    tcc_timer u_tcc_timer (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .addr_i(addr_i), .wr_data_i(wr_data_i),
        .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
        .timer_input_a_i(pin_a), .timer_input_b_i(pin_b),
        .cc_zero_match_irq_o(cc_zero_match_irq_o), .irq_o(irq_o)
    );
    tcc_pin_model u_tcc_pin_model (
        .clk_sys_i(clk_sys_i),
        .timer_input_a_o(pin_a), .timer_input_b_o(pin_b)
    );

    // verdict, reached from the main sequence or the watchdog
    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // word compare, case equality so unknowns fail
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_en_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_en_i <= 1'b0;
    endtask

    // one-cycle read strobe, data taken in the following cycle only
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_en_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_en_i <= 1'b0;
        #1 d = rd_data_o;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        rd(a, rv);
        chk(rv, exp);
    endtask

    // cycles until the next register-zero pulse, bounded
    task automatic wait_pulse(output logic [15:0] n);
        n = 16'h0000;
        do begin
            @(posedge clk_sys_i);
            #1 n++;
        end while (cc_zero_match_irq_o !== 1'b1 && n < 16'h0100);
    endtask

    // reset values and an unmapped address
    task automatic t_reset;
        rd_chk(TCC_ADR_COUNT, TCC_RST_COUNT);
        rd_chk(TCC_ADR_CC0, TCC_RST_CC0);
        rd_chk(TCC_ADR_IRQ_ST, 16'h0000);
        rd_chk(TCC_ADR_IRQ_EN, 16'h0000);
        rd_chk(16'hff00, 16'h0000);
    endtask

    // word write of register zero, count ignores writes, runs and stops
    task automatic t_run;
        wr(TCC_ADR_CC0, 16'ha5c3);
        rd_chk(TCC_ADR_CC0, 16'ha5c3);
        wr(TCC_ADR_COUNT, 16'h1234);
        rd_chk(TCC_ADR_COUNT, 16'h0000);
        wr(TCC_ADR_MODE, 16'h0004);
        rd(TCC_ADR_COUNT, rv);
        rd(TCC_ADR_COUNT, rv2);
        chk(rv2 - rv, 16'h0002);
        wr(TCC_ADR_COUNT, 16'h0000);
        rd(TCC_ADR_COUNT, rv2);
        chk(rv2 - rv, 16'h0006);
        wr(TCC_ADR_MODE, 16'h0000);
        rd_chk(TCC_ADR_COUNT, 16'h0000);
    endtask

    // clear on match, interrupt masked, enabled, cleared
    task automatic t_match;
        wr(TCC_ADR_CCCTL, 16'h0000);
        wr(TCC_ADR_CC0, 16'h0005);
        wr(TCC_ADR_MODE, 16'h000c);
        wait_pulse(rv);
        wait_pulse(rv);
        chk(rv, 16'h0006);
        chk({15'h0, irq_o}, 16'h0000);
        rd_chk(TCC_ADR_IRQ_ST, 16'h0001);
        wr(TCC_ADR_IRQ_EN, 16'h0001);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk({15'h0, irq_o}, 16'h0001);
        rd_chk(TCC_ADR_CC0, 16'h0005);
        wr(TCC_ADR_MODE, 16'h0000);
        wr(TCC_ADR_IRQ_CLR, 16'h0001);
        rd_chk(TCC_ADR_IRQ_ST, 16'h0000);
        chk({15'h0, irq_o}, 16'h0000);
        wr(TCC_ADR_IRQ_EN, 16'h0000);
    endtask

    // one-shot trigger clears a running count; trigger reads back 0
    task automatic t_oneshot;
        wr(TCC_ADR_MODE, 16'h0004);
        repeat (50) @(posedge clk_sys_i);
        wr(TCC_ADR_OSHOT, 16'h0002);
        wr(TCC_ADR_OSHOT, 16'h0003);
        rd(TCC_ADR_COUNT, rv);
        chk({15'h0, rv < 16'h0004}, 16'h0001);
        rd_chk(TCC_ADR_OSHOT, 16'h0002);
        wr(TCC_ADR_OSHOT, 16'h0000);
        wr(TCC_ADR_MODE, 16'h0000);
    endtask

    // rising edge on input a clears the count in edge-clear mode
    task automatic t_edge_clr;
        wr(TCC_ADR_EDGE, 16'h0010);
        wr(TCC_ADR_MODE, 16'h0008);
        repeat (60) @(posedge clk_sys_i);
        u_tcc_pin_model.drive_pin(1'b0, 1'b1);
        rd(TCC_ADR_COUNT, rv);
        chk({15'h0, rv < 16'h0010}, 16'h0001);
        u_tcc_pin_model.drive_pin(1'b0, 1'b0);
        rd(TCC_ADR_COUNT, rv);
        chk({15'h0, rv > 16'h0004}, 16'h0001);
        wr(TCC_ADR_EDGE, 16'h0030);
        repeat (20) @(posedge clk_sys_i);
        u_tcc_pin_model.drive_pin(1'b0, 1'b1);
        rd(TCC_ADR_COUNT, rv);
        chk({15'h0, rv < 16'h0010}, 16'h0001);
        wr(TCC_ADR_EDGE, 16'h0000);
        repeat (20) @(posedge clk_sys_i);
        u_tcc_pin_model.drive_pin(1'b0, 1'b0);
        rd(TCC_ADR_COUNT, rv);
        chk({15'h0, rv < 16'h0010}, 16'h0001);
        wr(TCC_ADR_MODE, 16'h0000);
    endtask

    // capture per source and edge code: {src, code, on rise, on fall}
    task automatic t_capture;
        logic [4:0] c;
        logic [4:0] tbl [6];
        tbl = '{5'b10101, 5'b10010, 5'b11100,
                5'b00001, 5'b00110, 5'b01111};
        for (int i = 0; i < 6; i++) begin
            c = tbl[i];
            wr(TCC_ADR_MODE, 16'h0000);
            wr(TCC_ADR_CC0, 16'h0000);
            wr(TCC_ADR_CCCTL, {14'h0, c[4], 1'b1});
            wr(TCC_ADR_EDGE, {8'h0, c[3:2], c[3:2], 4'h0});
            wr(TCC_ADR_MODE, 16'h0004);
            repeat (20) @(posedge clk_sys_i);
            u_tcc_pin_model.drive_pin(~c[4], 1'b1);
            rd(TCC_ADR_CC0, rv);
            chk({15'h0, rv != 16'h0}, {15'h0, c[1]});
            u_tcc_pin_model.drive_pin(~c[4], 1'b0);
            rd(TCC_ADR_CC0, rv2);
            chk({15'h0, rv2 != rv}, {15'h0, c[0]});
        end
    endtask

    // reset in mid-run returns count and register zero to zero
    task automatic t_rerun;
        wr(TCC_ADR_MODE, 16'h0000);
        wr(TCC_ADR_CC0, 16'h1111);
        wr(TCC_ADR_MODE, 16'h0004);
        repeat (10) @(posedge clk_sys_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        chk(u_tcc_timer.count_q, TCC_RST_COUNT);
        reset_n_i <= 1'b1;
        rd_chk(TCC_ADR_COUNT, 16'h0000);
        rd_chk(TCC_ADR_CC0, 16'h0000);
        rd_chk(TCC_ADR_MODE, 16'h0000);
    endtask

    // main sequence
    initial begin
        repeat (8) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_run();
        t_match();
        t_oneshot();
        t_edge_clr();
        t_capture();
        t_rerun();
        complete_run();
    end

    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #(100 * 20000);
        miscompares++;
        complete_run();
    end
endmodule // tcc_timer_test
`default_nettype wire
